// ---- logic/sut_core.v ----
`timescale 1ns/1ns
`include "sut_consts.vh"
// How it works
// - parity one gives even or odd total
// - spi frames carry eight bits, selectable order
// - spi frames chain or line idles high
// - enabled transmitter drives the output pin level, gpio_dir_in sets its direction
// - buffer loads shifter when idle or done
// - tx complete when frame out, buffer empty
// - surplus upper transmit bits are ignored
// - tx disable waits for pending data
// - disabled transmitter releases pin to input
// - receiver shifts bits up to first stop
// - first stop moves frame to buffer, flags
// - unused upper receive bits read zero
// - error flags travel with frame in fifo
// - parity checked, mismatch flags parity error
// - rx disable flushes buffer, drops frame
// - oversample sixteen, or eight double speed
// - start bit voted on middle three samples
// - majority vote per bit, bad stop flags
// - start, five to nine data, parity, stops
// - idle lines rest high
module sut_core (
  // clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  // configuration
  input  wire       tx_enable_in,
  input  wire       rx_enable_in,
  input  wire       spi_mode_in,
  input  wire       msb_first_in,
  input  wire       double_speed_in,
  input  wire       two_stop_in,
  input  wire [2:0] char_size_in,
  input  wire [1:0] parity_mode_in,
  input  wire       sample_tick_in,
  // transmit side of software
  input  wire       tx_write_in,
  input  wire [7:0] tx_data_in,
  input  wire       tx_ninth_bit_in,
  input  wire       tx_complete_clear_in,
  output reg        tx_buffer_empty_flag_out,
  output reg        tx_complete_flag_out,
  output reg        tx_enabled_out,
  // receive side of software
  input  wire       rx_read_in,
  output wire       rx_complete_flag_out,
  output wire [7:0] rx_data_out,
  output wire       rx_ninth_bit_out,
  output wire       frame_error_flag_out,
  output wire       parity_error_flag_out,
  output wire       rx_overflow_flag_out,
  // port pins
  input  wire       gpio_value_in,
  input  wire       gpio_dir_in,
  input  wire       serial_in_pin_in,
  output reg        serial_out_pin_n_out,
  output reg        serial_out_pin_n_oe_out,
  output reg        transfer_clock_pin_out,
  output reg        transfer_clock_pin_oe_out
);
  // ************************************************
  // shared helpers
  // ************************************************
  function [3:0] char_len;
    input [2:0] cs;
    begin
      char_len = (cs == `SUT_CS_9) ? 4'h9 : ({1'b0, cs} + 4'h5);
    end
  endfunction
  function maj3;
    input a;
    input b;
    input c;
    begin
      maj3 = (a & b) | (a & c) | (b & c);
    end
  endfunction
  // ************************************************
  // transmit control
  // ************************************************
  reg        tx_buf_full_reg;   // buffer holds a character
  reg  [8:0] tx_buf_reg;        // buffered character
  wire       tx_busy;           // shifter sending
  wire       tx_done;           // last stop bit just ended
  wire       tx_line;           // shifter output level
  wire       tx_xck;            // spi transfer clock
  wire       spi_sample;        // spi sample strobe
  // loading on done lets back to back frames follow after one clock of idle line
  wire       tx_load = tx_buf_full_reg & (~tx_busy | tx_done);
  // writes while full are dropped: software must wait for empty
  wire       tx_take = tx_write_in & tx_enabled_out & ~tx_buf_full_reg;
  wire       tx_full_next = tx_take | (tx_buf_full_reg & ~tx_load);
  sut_tx_shift u_tx (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .tick_in         (sample_tick_in),
    .spi_mode_in     (spi_mode_in),
    .double_speed_in (double_speed_in),
    .msb_first_in    (msb_first_in),
    .two_stop_in     (two_stop_in),
    .char_size_in    (char_size_in),
    .parity_mode_in  (parity_mode_in),
    .load_in         (tx_load),
    .data_in         (tx_buf_reg),
    .busy_out        (tx_busy),
    .done_out        (tx_done),
    .line_out        (tx_line),
    .xck_out         (tx_xck),
    .sample_out      (spi_sample)
  );
  // buffer, enable and completion flag
  always @(posedge clk_in) begin
    if (rst_in) begin
      tx_buf_full_reg          <= 1'b0;
      tx_buf_reg               <= 9'h000;
      tx_enabled_out           <= 1'b0;
      tx_complete_flag_out     <= 1'b0;
      tx_buffer_empty_flag_out <= 1'b1;
    end else begin
      tx_buf_full_reg          <= tx_full_next;
      tx_buffer_empty_flag_out <= ~tx_full_next;
      if (tx_take) begin
        // ninth bit sampled with the low byte
        tx_buf_reg <= {tx_ninth_bit_in, tx_data_in};
      end
      // a write taken in the same cycle still counts as pending data
      if (tx_enable_in) begin
        tx_enabled_out <= 1'b1;
      end else if (~tx_busy && ~tx_buf_full_reg && ~tx_take) begin
        tx_enabled_out <= 1'b0;
      end
      // set wins over a clear in the same cycle
      if (tx_done && ~tx_buf_full_reg) begin
        tx_complete_flag_out <= 1'b1;
      end else if (tx_complete_clear_in) begin
        tx_complete_flag_out <= 1'b0;
      end
    end
  end
  // pin override, registered so outputs come from flops
  always @(posedge clk_in) begin
    if (rst_in) begin
      serial_out_pin_n_out      <= 1'b1;
      serial_out_pin_n_oe_out   <= 1'b0;
      transfer_clock_pin_out    <= 1'b0;
      transfer_clock_pin_oe_out <= 1'b0;
    end else begin
      if (tx_enabled_out) begin
        serial_out_pin_n_out    <= tx_line;
        serial_out_pin_n_oe_out <= gpio_dir_in;
      end else begin
        serial_out_pin_n_out    <= gpio_value_in;
        serial_out_pin_n_oe_out <= 1'b0;
      end
      transfer_clock_pin_out    <= tx_xck;
      transfer_clock_pin_oe_out <= spi_mode_in & tx_enabled_out;
    end
  end
  // ************************************************
  // receiver
  // ************************************************
  reg  [2:0]  rx_state_reg;   // frame position
  reg  [3:0]  rx_cnt_reg;     // sample number inside bit
  reg  [1:0]  rx_hist_reg;    // two previous samples
  reg         rx_prev_reg;    // last sample, edge detect
  reg  [3:0]  rx_bit_reg;     // data bits taken
  reg  [8:0]  rx_shift_reg;   // receive shift register
  reg         rx_par_reg;     // received parity bit
  reg         rx_done_reg;    // frame complete pulse
  reg  [11:0] rx_word_reg;    // {frame_error_flag, parity_error_flag, ovf, data}
  wire [3:0]  len = char_len(char_size_in);
  wire [3:0]  last = double_speed_in ? `SUT_OS_DOUBLE : `SUT_OS_NORMAL;
  wire [3:0]  vote_pt = double_speed_in ? `SUT_VOTE_DOUBLE : `SUT_VOTE_NORMAL;
  wire        rx_on = rx_enable_in;
  wire        async_tick = sample_tick_in & rx_on & ~spi_mode_in;
  wire        vote_now = (rx_cnt_reg == vote_pt);
  wire        vote = maj3(rx_hist_reg[1], rx_hist_reg[0], serial_in_pin_in);
  // data left aligned after the shifts, align down, upper bits zero
  wire [8:0]  rx_data = rx_shift_reg >> (4'h9 - len);
  wire        rx_parity_error_flag = parity_mode_in[1] & (((^rx_data) ^ parity_mode_in[0]) != rx_par_reg);
  always @(posedge clk_in) begin
    if (rst_in || !rx_on) begin
      // disable is immediate: partial frame dropped
      rx_state_reg <= `SUT_RX_IDLE;
      rx_cnt_reg   <= 4'h0;
      rx_hist_reg  <= 2'h3;
      rx_prev_reg  <= 1'b1;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_par_reg   <= 1'b0;
      rx_done_reg  <= 1'b0;
      rx_word_reg  <= 12'h000;
    end else begin
      rx_done_reg <= 1'b0;
      if (spi_mode_in) begin
        // spi: sample on the transmitter's strobe, no error flags
        if (spi_sample) begin
          rx_shift_reg[7:0] <= msb_first_in ? {rx_shift_reg[6:0], serial_in_pin_in} :
                               {serial_in_pin_in, rx_shift_reg[7:1]};
          if (rx_bit_reg == `SUT_SPI_BITS - 4'h1) begin
            rx_bit_reg  <= 4'h0;
            rx_done_reg <= 1'b1;
            rx_word_reg <= {4'h0, msb_first_in ? {rx_shift_reg[6:0], serial_in_pin_in} :
                           {serial_in_pin_in, rx_shift_reg[7:1]}};
          end else begin
            rx_bit_reg <= rx_bit_reg + 4'h1;
          end
        end
      end else if (async_tick) begin
        rx_hist_reg <= {rx_hist_reg[0], serial_in_pin_in};
        rx_prev_reg <= serial_in_pin_in;
        // zero stands for the last sample of a bit, so a bit is last+1 ticks
        rx_cnt_reg  <= (rx_cnt_reg == last) ? 4'h0 : rx_cnt_reg + 4'h1;
        case (rx_state_reg)
          `SUT_RX_IDLE: begin
            // first low sample after high counts as sample one
            if (rx_prev_reg && !serial_in_pin_in) begin
              rx_state_reg <= `SUT_RX_START;
              rx_cnt_reg   <= 4'h2;
            end else begin
              rx_cnt_reg <= 4'h1;
            end
          end
          `SUT_RX_START: begin
            if (vote_now && vote) begin
              // noise spike, rescan for next falling edge
              rx_state_reg <= `SUT_RX_IDLE;
            end else if (rx_cnt_reg == last) begin
              rx_state_reg <= `SUT_RX_DATA;
              rx_bit_reg   <= 4'h0;
            end
          end
          `SUT_RX_DATA: begin
            if (vote_now) begin
              // lsb first into the top of the shifter
              rx_shift_reg <= {vote, rx_shift_reg[8:1]};
              rx_bit_reg   <= rx_bit_reg + 4'h1;
              if (rx_bit_reg + 4'h1 == len) begin
                rx_state_reg <= parity_mode_in[1] ? `SUT_RX_PAR : `SUT_RX_STOP;
              end
            end
          end
          `SUT_RX_PAR: begin
            if (vote_now) begin
              rx_par_reg   <= vote;
              rx_state_reg <= `SUT_RX_STOP;
            end
          end
          `SUT_RX_STOP: begin
            // done at the vote; a second stop bit is never looked at
            if (vote_now) begin
              rx_state_reg <= `SUT_RX_IDLE;
              rx_done_reg  <= 1'b1;
              rx_word_reg  <= {~vote, rx_parity_error_flag, 1'b0, rx_data};
            end
          end
          default: begin
            rx_state_reg <= `SUT_RX_IDLE;
          end
        endcase
      end
    end
  end
  // ************************************************
  // hand-off into the receive fifo
  // ************************************************
  reg         hold_valid_reg;  // frame waiting for room
  reg  [11:0] hold_word_reg;   // waiting frame, overflow set if buffer was full
  wire        fifo_full;
  wire [11:0] fifo_head;
  wire        fifo_push = hold_valid_reg ? ~fifo_full : (rx_done_reg & ~fifo_full);
  wire [11:0] fifo_data = hold_valid_reg ? hold_word_reg : rx_word_reg;
  always @(posedge clk_in) begin
    if (rst_in || !rx_on) begin
      hold_valid_reg <= 1'b0;
      hold_word_reg  <= 12'h000;
    end else if (rx_done_reg && (hold_valid_reg || fifo_full)) begin
      // flag rides with the frame that hit a full buffer
      hold_valid_reg <= 1'b1;
      hold_word_reg  <= rx_word_reg | {2'h0, fifo_full, 9'h000};
    end else if (hold_valid_reg && !fifo_full) begin
      hold_valid_reg <= 1'b0;
    end
  end
  sut_rx_fifo u_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .flush_in      (~rx_on),
    .push_in       (fifo_push),
    .push_data_in  (fifo_data),
    .pop_in        (rx_read_in),
    .head_out      (fifo_head),
    .not_empty_out (rx_complete_flag_out),
    .full_out      (fifo_full)
  );
  // head word fields; spi mode stores zero frame and parity flags
  assign rx_data_out           = fifo_head[7:0];
  assign rx_ninth_bit_out      = fifo_head[8];
  assign rx_overflow_flag_out  = fifo_head[9];
  assign parity_error_flag_out = fifo_head[10];
  assign frame_error_flag_out  = fifo_head[11];
endmodule

// ---- logic/sut_consts.vh ----
`ifndef SUT_CONSTS_VH
`define SUT_CONSTS_VH
// ************************************************
// character size codes
// ************************************************
`define SUT_CS_5        3'h0
`define SUT_CS_6        3'h1
`define SUT_CS_7        3'h2
`define SUT_CS_8        3'h3
`define SUT_CS_9        3'h4
// ************************************************
// parity mode codes
// ************************************************
`define SUT_PAR_NONE    2'h0
`define SUT_PAR_EVEN    2'h2
`define SUT_PAR_ODD     2'h3
// ************************************************
// oversampling and voting points
// ************************************************
`define SUT_OS_NORMAL   4'hF
`define SUT_OS_DOUBLE   4'h7
`define SUT_VOTE_NORMAL 4'hA
`define SUT_VOTE_DOUBLE 4'h6
`define SUT_SPI_BITS    4'h8
`define SUT_SPI_HALF    4'h1
// ************************************************
// receiver states
// ************************************************
`define SUT_RX_IDLE     3'h0
`define SUT_RX_START    3'h1
`define SUT_RX_DATA     3'h2
`define SUT_RX_PAR      3'h3
`define SUT_RX_STOP     3'h4
// ************************************************
// receive fifo shape: 9 data bits plus 3 flags
// ************************************************
`define SUT_FIFO_W      12
`define SUT_FIFO_AW     1
`endif

// ---- logic/sut_rx_fifo.v ----
`timescale 1ns/1ns
`include "sut_consts.vh"
// two-entry receive fifo, head word held in a register
module sut_rx_fifo (
  // clock and reset
  input  wire                   clk_in,
  input  wire                   rst_in,
  // control
  input  wire                   flush_in,
  input  wire                   push_in,
  input  wire [`SUT_FIFO_W-1:0] push_data_in,
  input  wire                   pop_in,
  // state
  output reg  [`SUT_FIFO_W-1:0] head_out,
  output reg                    not_empty_out,
  output reg                    full_out
);
  reg [`SUT_FIFO_W-1:0] mem_reg [0:1];  // storage
  reg                   wr_ptr_reg;     // write pointer
  reg                   rd_ptr_reg;     // read pointer
  reg [1:0]             count_reg;      // words held
  wire                  do_push = push_in & ~full_out;
  wire                  do_pop  = pop_in & not_empty_out;
  wire                  rd_next = rd_ptr_reg ^ do_pop;
  wire [1:0]            cnt_next = count_reg + {1'b0, do_push} - {1'b0, do_pop};
  // ************************************************
  // pointers, storage and registered head
  // ************************************************
  always @(posedge clk_in) begin
    if (rst_in || flush_in) begin
      wr_ptr_reg    <= 1'b0;
      rd_ptr_reg    <= 1'b0;
      count_reg     <= 2'h0;
      not_empty_out <= 1'b0;
      full_out      <= 1'b0;
      head_out      <= {`SUT_FIFO_W{1'b0}};
    end else begin
      if (do_push) begin
        mem_reg[wr_ptr_reg] <= push_data_in;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      rd_ptr_reg    <= rd_next;
      count_reg     <= cnt_next;
      not_empty_out <= (cnt_next != 2'h0);
      full_out      <= (cnt_next == 2'h2);
      // bypass so a word written into the next head slot is seen at once
      if (do_push && (wr_ptr_reg == rd_next)) begin
        head_out <= push_data_in;
      end else begin
        head_out <= mem_reg[rd_next];
      end
    end
  end
endmodule

// ---- logic/sut_tx_shift.v ----
`timescale 1ns/1ns
`include "sut_consts.vh"
// transmit shift register, async frames and master spi frames
module sut_tx_shift (
  // clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  // format
  input  wire       tick_in,
  input  wire       spi_mode_in,
  input  wire       double_speed_in,
  input  wire       msb_first_in,
  input  wire       two_stop_in,
  input  wire [2:0] char_size_in,
  input  wire [1:0] parity_mode_in,
  // load
  input  wire       load_in,
  input  wire [8:0] data_in,
  // state and line
  output reg        busy_out,
  output reg        done_out,
  output wire       line_out,
  output reg        xck_out,
  output reg        sample_out
);
  reg  [11:0] frame_reg;   // bits still to send, lsb goes out
  reg  [3:0]  left_reg;    // bits still to send
  reg  [3:0]  cnt_reg;     // ticks inside current bit
  reg  [11:0] frame_new;   // frame built at load
  reg  [3:0]  bits_new;
  reg  [8:0]  d;
  reg  [3:0]  len;
  integer     i;
  wire [3:0]  last = spi_mode_in ? `SUT_SPI_HALF :
                     (double_speed_in ? `SUT_OS_DOUBLE : `SUT_OS_NORMAL);
  // idle frame is all ones, so the line rests high
  assign line_out = frame_reg[0];
  // ************************************************
  // frame builder
  // ************************************************
  always @* begin
    frame_new = 12'hFFF;
    len       = (char_size_in == `SUT_CS_9) ? 4'h9 : ({1'b0, char_size_in} + 4'h5);
    d         = data_in & ~(9'h1FF << len);
    if (spi_mode_in) begin
      bits_new = `SUT_SPI_BITS;
      for (i = 0; i < 8; i = i + 1) begin
        frame_new[i] = msb_first_in ? d[7-i] : d[i];
      end
    end else begin
      frame_new[0] = 1'b0;
      for (i = 0; i < 9; i = i + 1) begin
        if (i < len) begin
          frame_new[i+1] = d[i];
        end
      end
      bits_new = len + 4'h2 + {3'h0, two_stop_in};
      if (parity_mode_in[1]) begin
        // even parity bit is one on an odd count of ones
        frame_new[len+1] = (^d) ^ parity_mode_in[0];
        bits_new         = bits_new + 4'h1;
      end
    end
  end
  // ************************************************
  // bit timing and shifting
  // ************************************************
  always @(posedge clk_in) begin
    if (rst_in) begin
      frame_reg  <= 12'hFFF;
      left_reg   <= 4'h0;
      cnt_reg    <= 4'h0;
      busy_out   <= 1'b0;
      done_out   <= 1'b0;
      xck_out    <= 1'b0;
      sample_out <= 1'b0;
    end else begin
      done_out   <= 1'b0;
      sample_out <= 1'b0;
      if (load_in) begin
        // one load sends one whole frame
        frame_reg <= frame_new;
        left_reg  <= bits_new;
        cnt_reg   <= 4'h0;
        busy_out  <= 1'b1;
        xck_out   <= 1'b0;
      end else if (busy_out && tick_in) begin
        if (cnt_reg == last) begin
          cnt_reg   <= 4'h0;
          frame_reg <= {1'b1, frame_reg[11:1]};
          left_reg  <= left_reg - 4'h1;
          xck_out   <= 1'b0;
          if (left_reg == 4'h1) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
          // spi: clock rises mid bit, receiver samples there
          if (spi_mode_in) begin
            xck_out    <= 1'b1;
            sample_out <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ---- verif/sut_core_assertions.sv ----
`timescale 1ns/1ns
`include "sut_consts.vh"
// ******************************
// port checker for the core
// ******************************
module sut_core_assertions (
  // clock and reset
  input wire       clk_in,
  input wire       rst_in,
  // watched inputs
  input wire       tx_enable_in,
  input wire       rx_enable_in,
  input wire [2:0] char_size_in,
  input wire       tx_write_in,
  input wire       gpio_dir_in,
  // watched outputs
  input wire       tx_buffer_empty_flag_out,
  input wire       tx_complete_flag_out,
  input wire       tx_enabled_out,
  input wire       rx_complete_flag_out,
  input wire [7:0] rx_data_out,
  input wire       serial_out_pin_n_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // pin enable follows the flop, so allow one cycle of lag
  pin_release_a: assert property (!tx_enabled_out && !$past(tx_enabled_out) |->
    !serial_out_pin_n_oe_out) else $error("pin driven while off");
  pin_drive_a: assert property (tx_enabled_out && $past(tx_enabled_out) && gpio_dir_in
    && $past(gpio_dir_in) |-> serial_out_pin_n_oe_out) else $error("pin not driven");
  enable_cause_a: assert property ($rose(tx_enabled_out) |-> $past(tx_enable_in))
    else $error("enabled unasked");
  write_take_a: assert property (tx_write_in && tx_enabled_out &&
    tx_buffer_empty_flag_out |=> !tx_buffer_empty_flag_out) else $error("write lost");
  write_refuse_a: assert property (tx_write_in && !tx_enabled_out &&
    tx_buffer_empty_flag_out |=> tx_buffer_empty_flag_out) else $error("write taken off");
  done_empty_a: assert property ($rose(tx_complete_flag_out) |->
    $past(tx_buffer_empty_flag_out)) else $error("complete with data pending");
  disable_wait_a: assert property ($fell(tx_enabled_out) |-> !$past(tx_enable_in)
    && tx_buffer_empty_flag_out) else $error("early disable");
  rx_flush_a: assert property (!rx_enable_in |-> ##[1:2] !rx_complete_flag_out)
    else $error("buffer kept");
  upper_zero_a: assert property (rx_complete_flag_out && char_size_in < `SUT_CS_8 |->
    (rx_data_out >> (5 + char_size_in)) == 8'h00) else $error("upper bits set");
endmodule
bind sut_core sut_core_assertions u_chk (.*);

// ---- verif/sut_line_partner.sv ----
`timescale 1ns/1ns
// ******************************
// remote transceiver on the line
// ******************************
module sut_line_partner (
  input  wire clk_in,  // bench clock
  input  wire line_in, // our transmit line
  output reg  line_out // our receive line
);
  integer i;
  integer t;
  initial line_out = 1'h1;
  // n bits lsb first, len cycles each, then idle high
  task send(input [15:0] f, input integer n, input integer len);
    for (i = 0; i < n; i = i + 1) begin
      @(posedge clk_in);
      line_out <= f[i];
      repeat (len - 1) @(posedge clk_in);
    end
    @(posedge clk_in);
    line_out <= 1'h1;
  endtask
  // waits for start, samples mid bit; ends at last mid so a next start is seen
  task catch(input integer n, input integer len, output [15:0] f);
    f = 16'h0000;
    t = 0;
    while (line_in !== 1'h0 && t < 5000) begin
      @(negedge clk_in);
      t = t + 1;
    end
    repeat (len / 2) @(negedge clk_in);
    for (i = 0; i < n; i = i + 1) begin
      f[i] = line_in;
      if (i < n - 1) repeat (len) @(negedge clk_in);
    end
  endtask
endmodule

// ---- verif/tb_sut_core.sv ----
`timescale 1ns/1ns
`include "sut_consts.vh"
// ******************************
// bench around the core
// ******************************
module tb_sut_core;
  reg         clk_in, rst_in, tx_en, rx_en, dbl, two_stop, msb, wr, nin, clr, rd, gval, spi;
  reg  [2:0]  cs;
  reg  [1:0]  pm;
  reg  [7:0]  txd;
  reg  [15:0] f, got;
  reg  [8:0]  d, d2, e;
  reg  [31:0] seed;
  integer     error_cnt, total_checks, cyc, k, j, n, len, t, xn;
  wire        tbe, tcf, ten, rcf, r9, fe, pe, ov, sout, soe, rxl, transfer_clock_pin, xoe;
  wire [7:0]  rdat;
  wire        txl = soe ? sout : 1'h1; // pull-up when released
  sut_core uut (.clk_in(clk_in), .rst_in(rst_in), .tx_enable_in(tx_en),
    .rx_enable_in(rx_en), .spi_mode_in(spi), .msb_first_in(msb), .double_speed_in(dbl),
    .two_stop_in(two_stop), .char_size_in(cs), .parity_mode_in(pm), .sample_tick_in(1'h1),
    .tx_write_in(wr), .tx_data_in(txd), .tx_ninth_bit_in(nin), .tx_complete_clear_in(clr),
    .tx_buffer_empty_flag_out(tbe), .tx_complete_flag_out(tcf), .tx_enabled_out(ten),
    .rx_read_in(rd), .rx_complete_flag_out(rcf), .rx_data_out(rdat), .rx_ninth_bit_out(r9),
    .frame_error_flag_out(fe), .parity_error_flag_out(pe), .rx_overflow_flag_out(ov),
    .gpio_value_in(gval), .gpio_dir_in(1'h1), .serial_in_pin_in(rxl),
    .serial_out_pin_n_out(sout), .serial_out_pin_n_oe_out(soe),
    .transfer_clock_pin_out(transfer_clock_pin), .transfer_clock_pin_oe_out(xoe));
  sut_line_partner p (.clk_in(clk_in), .line_in(txl), .line_out(rxl));
  // expected frame: start, data lsb first, parity, stop s, idle ones above
  function [15:0] frm(input [8:0] dd, input [2:0] c, input [1:0] pp, input s);
    integer i;
    frm = 16'hFFFF;
    frm[0] = 1'h0;
    for (i = 0; i < 5 + c; i = i + 1) frm[i + 1] = dd[i];
    if (pp[1]) frm[6 + c] = ^(dd & ((9'h001 << (5 + c)) - 9'h001)) ^ pp[0];
    frm[6 + c + pp[1]] = s;
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one write pulse, ninth bit with the low byte
  task wr_byte(input [8:0] v);
    @(posedge clk_in);
    wr <= 1'h1;
    txd <= v[7:0];
    nin <= v[8];
    @(posedge clk_in);
    wr <= 1'h0;
  endtask
  task pop;
    @(posedge clk_in);
    rd <= 1'h1;
    @(posedge clk_in);
    rd <= 1'h0;
  endtask
  // bounded waits; first lets the launching edge land
  task wait_tbe;
    t = 0;
    do begin
      @(negedge clk_in);
      t = t + 1;
    end while (tbe !== 1'h1 && t < 50);
  endtask
  task rx_wait;
    t = 0;
    repeat (2) @(negedge clk_in);
    while (rcf !== 1'h1 && t < 80) begin
      @(negedge clk_in);
      t = t + 1;
    end
  endtask
  // next format from the loop index
  task setup(input integer i);
    @(posedge clk_in);
    cs <= 3'(i % 5);
    pm <= (i % 3 == 0) ? `SUT_PAR_NONE : (i % 3 == 1) ? `SUT_PAR_EVEN : `SUT_PAR_ODD;
    dbl <= i / 5;
    two_stop <= $random(seed);
    msb <= $random(seed);
    gval <= $random(seed);
    d = $random(seed);
    d2 = $random(seed);
    @(posedge clk_in);
    len = dbl ? 8 : 16;
    n = 7 + cs + pm[1];
  endtask
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end
  // transfer clock rising edges, counted per spi frame
  always @(posedge transfer_clock_pin) xn = xn + 1;
  // hang guard
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      results;
    end
  end
  initial begin
    {rst_in, tx_en, rx_en, dbl, two_stop, msb, wr, nin, clr, rd, gval} = 11'h400;
    {spi, cs, pm, txd} = 14'h0000;
    {error_cnt, total_checks, cyc, xn} = 0;
    seed = 32'hE176;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'h0;
    @(negedge clk_in);
    check({tbe, tcf, ten, rcf, soe, txl}, 6'h21);
    @(posedge clk_in);
    tx_en <= 1'h1;
    rx_en <= 1'h1;
    // transmit: back to back pairs plus a refused third write
    for (k = 0; k < 10; k = k + 1) begin
      setup(k);
      clr <= 1'h1;
      wr_byte(d);
      clr <= 1'h0;
      wait_tbe;
      wr_byte(d2);
      wr_byte(~d2);
      p.catch(n, len, got);
      check(got, frm(d, cs, pm, 1'h1) & ((16'h1 << n) - 16'h1));
      check(tcf, 1'h0);
      p.catch(n, len, got);
      check(got, frm(d2, cs, pm, 1'h1) & ((16'h1 << n) - 16'h1));
      repeat (2 * len + 4) @(negedge clk_in);
      check({tcf, txl}, 2'h3);
    end
    // disable request while a frame is pending
    wr_byte(d);
    tx_en <= 1'h0;
    p.catch(n, len, got);
    check(got, frm(d, cs, pm, 1'h1) & ((16'h1 << n) - 16'h1));
    check(ten, 1'h1);
    repeat (2 * len + 4) @(negedge clk_in);
    check({ten, soe}, 2'h0);
    wr_byte(d);
    tx_en <= 1'h1;
    // receive: noise pulse, then frames with bad parity or bad stop
    for (k = 0; k < 10; k = k + 1) begin
      setup(k);
      f = frm(d, cs, pm, k != 3);
      if (k % 4 == 1 && pm[1]) f = f ^ (16'h1 << (6 + cs));
      p.send(16'h0000, 1, 2);
      repeat (40) @(posedge clk_in);
      check(rcf, 1'h0);
      p.send(f, n, len);
      rx_wait;
      e = d & ((9'h001 << (5 + cs)) - 9'h001);
      check({r9, rdat}, e);
      check({fe, pe, ov}, {k == 3, k % 4 == 1 && pm[1], 1'h0});
      pop;
    end
    // three frames into a two deep buffer, then disable flush
    for (j = 0; j < 3; j = j + 1) p.send(frm(9'(j), cs, pm, 1'h1), n, len);
    for (j = 0; j < 3; j = j + 1) begin
      rx_wait;
      check({ov, rdat}, {j == 2, 8'(j)});
      if (j < 2) pop;
    end
    @(posedge clk_in);
    rx_en <= 1'h0;
    repeat (3) @(negedge clk_in);
    check(rcf, 1'h0);
    // master spi: first bit low so the catch sees it, eight clocks a frame
    @(posedge clk_in);
    spi <= 1'h1;
    rx_en <= 1'h1;
    for (k = 0; k < 2; k = k + 1) begin
      msb <= k[0];
      xn = 0;
      d = $random(seed) & (k ? 9'h07F : 9'h0FE);
      wr_byte(d);
      p.catch(8, 2, got);
      for (j = 0; j < 8; j = j + 1) f[j] = k ? d[7 - j] : d[j];
      check(got[7:0], f[7:0]);
      rx_wait;
      check({xoe, txl, 8'(xn)}, 10'h308);
      check({fe, pe, ov, r9, rdat}, 12'h0FF);
      pop;
    end
    results;
  end
endmodule
